// ### logic/fcs_defs.svh
// timing counts and command codes for the flash command host controller
`ifndef FCS_DEFS_SVH
`define FCS_DEFS_SVH
// ==========================================
// command codes
`define FCS_CMD_READ 8'h00
`define FCS_CMD_READ_ALT 8'hff
`define FCS_CMD_IDENT 8'h90
`define FCS_CMD_ERASE 8'h30
`define FCS_CMD_PROG 8'h10
`define FCS_CMD_PROG_ALT 8'h50
`define FCS_ERASED_BYTE 8'hff
// ==========================================
// bus widths and positions
`define FCS_ADDR_W 15
`define FCS_DATA_W 8
`define FCS_STATUS_BIT 7
// ==========================================
// timing: clock period and phase lengths in ns
`define FCS_CLK_NS 25
`define FCS_SETUP_NS 50
`define FCS_STROBE_NS 100
`define FCS_ACCESS_NS 150
`define FCS_SETUP_CYC ((`FCS_SETUP_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_STROBE_CYC ((`FCS_STROBE_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_ACCESS_CYC ((`FCS_ACCESS_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_CNT_W 4
`endif

// ### logic/fcs_pkg.sv
// types for the flash command host controller
package fcs_pkg;
	// ==========================================
	// user operations
	typedef enum logic [2:0] {
		FCS_OP_READ,
		FCS_OP_RESET,
		FCS_OP_PROGRAM,
		FCS_OP_ERASE,
		FCS_OP_IDENT
	} fcs_op_t;
endpackage

// ### logic/fcs_bus_cycle.sv
// one timed cycle on the flash parallel bus, write or read
`timescale 1ns/1ps
`include "fcs_defs.svh"
module fcs_bus_cycle
	import fcs_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic start,
	input wire logic is_write,
	input wire logic [`FCS_ADDR_W-1:0] addr,
	input wire logic [`FCS_DATA_W-1:0] wdata,
	input wire logic [`FCS_DATA_W-1:0] dq_in,
	output logic [`FCS_ADDR_W-1:0] a_out,
	output logic [`FCS_DATA_W-1:0] dq_out,
	output logic dq_oe,
	output logic ce_n,
	output logic oe_n,
	output logic we_n,
	output logic [`FCS_DATA_W-1:0] rdata,
	output logic done
);
	typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_STROBE, CY_HOLD} fcs_cy_t;
	fcs_cy_t st_q, st_d;
	logic [`FCS_CNT_W-1:0] cnt_q, cnt_d;
	logic wr_q, wr_d;
	logic [`FCS_ADDR_W-1:0] a_d;
	logic [`FCS_DATA_W-1:0] dq_d, rd_d, sync1_q, sync2_q;
	logic dq_oe_d, ce_n_d, oe_n_d, we_n_d, done_d;
	// ==========================================
	// sequencing: address stable before we falls, data held past we rise
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		wr_d = wr_q;
		a_d = a_out;
		dq_d = dq_out;
		dq_oe_d = dq_oe;
		ce_n_d = ce_n;
		oe_n_d = oe_n;
		we_n_d = we_n;
		rd_d = rdata;
		done_d = 1'b0;
		unique case (st_q)
			CY_IDLE: begin
				if (start) begin
					st_d = CY_SETUP;
					wr_d = is_write;
					a_d = addr;
					dq_d = wdata;
					dq_oe_d = is_write;
					ce_n_d = 1'b0;
					oe_n_d = 1'b1; // oe high before any write
					cnt_d = `FCS_CNT_W'(`FCS_SETUP_CYC);
				end
			end
			CY_SETUP: begin
				if (cnt_q == '0) begin
					st_d = CY_STROBE;
					cnt_d = wr_q ? `FCS_CNT_W'(`FCS_STROBE_CYC) : `FCS_CNT_W'(`FCS_ACCESS_CYC);
					we_n_d = ~wr_q; // address latched on this fall
					oe_n_d = wr_q;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			CY_STROBE: begin
				if (cnt_q == '0) begin
					st_d = CY_HOLD;
					we_n_d = 1'b1; // data latched on this rise
					oe_n_d = 1'b1;
					if (!wr_q) begin
						rd_d = sync2_q;
					end
					cnt_d = `FCS_CNT_W'(`FCS_SETUP_CYC);
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			CY_HOLD: begin
				if (cnt_q == '0) begin
					st_d = CY_IDLE;
					ce_n_d = 1'b1;
					dq_oe_d = 1'b0;
					done_d = 1'b1;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
		endcase
	end
	// registers, strobes idle high, address and data low, data undriven after reset
	always_ff @(posedge clk) begin
		sync1_q <= dq_in;
		sync2_q <= sync1_q; // dq comes from the pins, so two stages
		if (!nrst) begin
			st_q <= CY_IDLE;
			cnt_q <= '0;
			wr_q <= 1'b0;
			a_out <= '0;
			dq_out <= '0;
			dq_oe <= 1'b0;
			ce_n <= 1'b1;
			oe_n <= 1'b1;
			we_n <= 1'b1;
			rdata <= '0;
			done <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			wr_q <= wr_d;
			a_out <= a_d;
			dq_out <= dq_d;
			dq_oe <= dq_oe_d;
			ce_n <= ce_n_d;
			oe_n <= oe_n_d;
			we_n <= we_n_d;
			rdata <= rd_d;
			done <= done_d;
		end
	end
endmodule // fcs_bus_cycle

// ### logic/fcs_host.sv
// host controller that issues command sequences to a parallel flash memory
`timescale 1ns/1ps
`include "fcs_defs.svh"
module fcs_host
	import fcs_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic req,
	input wire fcs_op_t op,
	input wire logic [`FCS_ADDR_W-1:0] addr,
	input wire logic [`FCS_DATA_W-1:0] wdata,
	input wire logic volt_req,
	output logic busy,
	output logic done,
	output logic [`FCS_DATA_W-1:0] rdata,
	output logic [`FCS_DATA_W-1:0] id_dev,
	output logic fail,
	output logic [`FCS_ADDR_W-1:0] flash_addr,
	input wire logic [`FCS_DATA_W-1:0] flash_dq_in,
	output logic [`FCS_DATA_W-1:0] flash_dq_out,
	output logic flash_dq_oe,
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n,
	output logic program_voltage_input
);
	typedef enum logic [2:0] {
		HS_IDLE,
		HS_CYCLE,
		HS_WAIT,
		HS_POLL,
		HS_FINISH
	} fcs_hs_t;
	fcs_hs_t st_q, st_d;
	fcs_op_t op_q, op_d;
	logic [2:0] step_q, step_d;
	logic [`FCS_ADDR_W-1:0] addr_q, addr_d;
	logic [`FCS_DATA_W-1:0] wdata_q, wdata_d;
	logic [`FCS_DATA_W-1:0] rdata_d, id_d;
	logic busy_d, done_d, fail_d, volt_d;
	logic cy_start, cy_write, cy_done;
	logic [`FCS_ADDR_W-1:0] cy_addr;
	logic [`FCS_DATA_W-1:0] cy_wdata, cy_rdata;
	// ==========================================
	// step tables: per operation, what each bus cycle is
	function automatic logic step_is_write(input fcs_op_t o, input logic [2:0] s);
		unique case (o)
			FCS_OP_READ: step_is_write = (s == 3'd0);
			FCS_OP_RESET: step_is_write = 1'b1;
			FCS_OP_PROGRAM: step_is_write = (s < 3'd2);
			FCS_OP_ERASE: step_is_write = (s < 3'd2);
			FCS_OP_IDENT: step_is_write = (s == 3'd0);
			default: step_is_write = 1'b0;
		endcase
	endfunction
	function automatic logic [2:0] last_step(input fcs_op_t o);
		unique case (o)
			FCS_OP_READ: last_step = 3'd1;
			FCS_OP_RESET: last_step = 3'd1;
			FCS_OP_PROGRAM: last_step = 3'd2;
			FCS_OP_ERASE: last_step = 3'd2;
			FCS_OP_IDENT: last_step = 3'd2;
			default: last_step = 3'd0;
		endcase
	endfunction
	// ==========================================
	// operation sequencer
	always_comb begin
		st_d = st_q;
		op_d = op_q;
		step_d = step_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		rdata_d = rdata;
		id_d = id_dev;
		busy_d = busy;
		done_d = 1'b0;
		fail_d = fail;
		volt_d = volt_req; // command register only live with voltage applied
		cy_start = 1'b0;
		cy_write = step_is_write(op_q, step_q);
		cy_addr = '0;
		cy_wdata = `FCS_CMD_READ;
		// data code selects operation; address is don't care except data steps
		unique case (op_q)
			FCS_OP_READ: begin
				cy_wdata = `FCS_CMD_READ;
				cy_addr = (step_q == 3'd0) ? '0 : addr_q;
			end
			FCS_OP_RESET: cy_wdata = `FCS_CMD_READ_ALT; // twice covers program setup
			FCS_OP_PROGRAM: begin
				cy_wdata = (step_q == 3'd0) ? `FCS_CMD_PROG : wdata_q;
				cy_addr = (step_q == 3'd0) ? '0 : addr_q;
			end
			FCS_OP_ERASE: begin
				cy_wdata = `FCS_CMD_ERASE; // staging write, then start write
				cy_addr = '0;
			end
			FCS_OP_IDENT: begin
				cy_wdata = `FCS_CMD_IDENT;
				cy_addr = (step_q == 3'd2) ? `FCS_ADDR_W'(1) : '0;
			end
			default: ;
		endcase
		unique case (st_q)
			HS_IDLE: begin
				if (req) begin
					st_d = HS_CYCLE;
					op_d = op;
					step_d = 3'd0;
					addr_d = addr;
					wdata_d = wdata;
					busy_d = 1'b1;
					fail_d = 1'b0;
				end
			end
			HS_CYCLE: begin
				cy_start = 1'b1; // bus unit gates ce/we/oe legally
				st_d = HS_WAIT;
			end
			HS_WAIT: begin
				if (cy_done) begin
					if (!cy_write) begin
						// device byte goes aside so rdata keeps the maker byte
						if (op_q == FCS_OP_IDENT && step_q == 3'd2) begin
							id_d = cy_rdata;
						end else begin
							rdata_d = cy_rdata;
						end
					end
					if (step_q == last_step(op_q)) begin
						// erase and program are polled on the status bit
						st_d = (op_q == FCS_OP_ERASE || op_q == FCS_OP_PROGRAM) ? HS_POLL : HS_FINISH;
						step_d = 3'd0;
					end else begin
						step_d = step_q + 3'd1;
						st_d = HS_CYCLE;
					end
				end
			end
			HS_POLL: begin
				// status read at target location; erase done when bit is one
				cy_write = 1'b0;
				cy_addr = addr_q;
				if (step_q == 3'd0) begin
					cy_start = 1'b1;
					step_d = 3'd1;
				end else if (cy_done) begin
					rdata_d = cy_rdata;
					step_d = 3'd0;
					if (op_q == FCS_OP_ERASE && cy_rdata[`FCS_STATUS_BIT]) begin
						st_d = HS_FINISH;
						// erased array must read all ones
						fail_d = (cy_rdata != `FCS_ERASED_BYTE);
					end else if (op_q == FCS_OP_PROGRAM &&
						cy_rdata[`FCS_STATUS_BIT] == wdata_q[`FCS_STATUS_BIT]) begin
						st_d = HS_FINISH;
					end
				end
			end
			HS_FINISH: begin
				busy_d = 1'b0;
				done_d = 1'b1;
				st_d = HS_IDLE;
			end
			default: st_d = HS_IDLE;
		endcase
	end
	// registers
	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_q <= HS_IDLE;
			op_q <= FCS_OP_READ;
			step_q <= 3'd0;
			addr_q <= '0;
			wdata_q <= '0;
			rdata <= '0;
			id_dev <= '0;
			busy <= 1'b0;
			done <= 1'b0;
			fail <= 1'b0;
			program_voltage_input <= 1'b0;
		end else begin
			st_q <= st_d;
			op_q <= op_d;
			step_q <= step_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			rdata <= rdata_d;
			id_dev <= id_d;
			busy <= busy_d;
			done <= done_d;
			fail <= fail_d;
			program_voltage_input <= volt_d;
		end
	end
	// ==========================================
	// bus cycle engine drives the pins straight from its flip-flops
	fcs_bus_cycle u_cycle (
		.clk(clk),
		.nrst(nrst),
		.start(cy_start),
		.is_write(cy_write),
		.addr(cy_addr),
		.wdata(cy_wdata),
		.dq_in(flash_dq_in),
		.a_out(flash_addr),
		.dq_out(flash_dq_out),
		.dq_oe(flash_dq_oe),
		.ce_n(flash_ce_n),
		.oe_n(flash_oe_n),
		.we_n(flash_we_n),
		.rdata(cy_rdata),
		.done(cy_done)
	);
endmodule // fcs_host

// ### tb/fcs_host_monitor.sv
// assertion checker watching the flash host controller ports
`timescale 1ns/1ps
module fcs_host_monitor (
	input wire logic clk,
	input wire logic nrst,
	input wire logic req,
	input wire logic volt_req,
	input wire logic busy,
	input wire logic done,
	input wire logic [7:0] rdata,
	input wire logic fail,
	input wire logic [14:0] flash_addr,
	input wire logic [7:0] flash_dq_out,
	input wire logic flash_dq_oe,
	input wire logic flash_ce_n,
	input wire logic flash_oe_n,
	input wire logic flash_we_n,
	input wire logic program_voltage_input
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// ====
	// strobe qualification and hold
	chk_write_qualified: assert property (!flash_we_n |-> flash_oe_n && !flash_ce_n)
		else $error("write strobe not qualified");
	chk_drive_write: assert property (!flash_we_n |-> flash_dq_oe)
		else $error("data not driven during write strobe");
	chk_bus_held: assert property (!flash_we_n && !$past(flash_we_n) |->
		$stable(flash_addr) && $stable(flash_dq_out))
		else $error("address or data moved inside strobe");
	chk_strobe_width: assert property ($fell(flash_we_n) |-> !flash_we_n[*5] ##1 flash_we_n)
		else $error("write strobe width wrong");
	// ====
	// sequencing
	chk_volt_follow: assert property ($past(nrst) |-> program_voltage_input == $past(volt_req))
		else $error("program voltage not following request");
	chk_take_req: assert property (req && !busy |=> busy)
		else $error("request not taken");
	chk_done_pulse: assert property (done |-> !busy ##1 !done)
		else $error("done not a single pulse");
	chk_idle_quiet: assert property (!busy && !done |-> flash_ce_n && flash_we_n && flash_oe_n)
		else $error("bus active while idle");
	chk_fail_byte: assert property (done && fail |-> rdata != 8'hff)
		else $error("fail flagged on erased byte");
endmodule // fcs_host_monitor

// ### tb/fcs_flash_model.sv
// behavioural model of the byte-wide flash device
`timescale 1ns/1ps
module fcs_flash_model #(
	parameter logic [7:0] MAN_ID = 8'h3c, // arbitrary value
	parameter logic [7:0] DEV_ID = 8'ha5, // arbitrary value
	parameter int POLLS = 3
) (
	input wire logic [14:0] a,
	input wire logic [7:0] d_in,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic hv_on,
	output logic [7:0] d_out
);
	logic [7:0] mem [0:32767];
	logic [7:0] cmd = 8'h00;
	logic [7:0] last = 8'h00;
	logic [14:0] la;
	logic erasing = 1'b0;
	logic pbit = 1'b0;
	int polls = 0;
	// ====
	// command path
	initial for (int i = 0; i < 32768; i++) mem[i] = i[7:0] ^ 8'h96;
	always @(hv_on) cmd = 8'h00;
	always @(negedge we_n) if (!ce_n && oe_n) la = a;
	always @(posedge we_n) if (!ce_n && oe_n && hv_on) begin
		if (cmd == 8'h10 || cmd == 8'h50) begin
			mem[la] = mem[la] & d_in;
			pbit = d_in[7];
			erasing = 1'b0;
			polls = 2;
			cmd = 8'h00;
		end else if (cmd == 8'h30 && d_in == 8'h30) begin
			for (int i = 0; i < 32768; i++) mem[i] = 8'h00;
			for (int i = 0; i < 32768; i++) mem[i] = 8'hff;
			erasing = 1'b1;
			polls = POLLS;
			cmd = 8'h00;
		end else if (cmd == 8'h30) cmd = 8'h00;
		else cmd = d_in;
	end
	// ====
	// read path; released pins show the inverse, not a held value
	always @* begin
		if (!ce_n && !oe_n) begin
			if (polls > 0) d_out = {erasing ? 1'b0 : ~pbit, 7'h00};
			else if (cmd == 8'h90) d_out = a[0] ? DEV_ID : MAN_ID;
			else d_out = mem[a];
		end else d_out = ~last;
	end
	always @(d_out) if (!ce_n && !oe_n) last = d_out;
	always @(posedge oe_n) if (!ce_n && polls > 0) polls--;
endmodule // fcs_flash_model

// ### tb/fcs_host_tb.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ps
module fcs_host_tb
	import fcs_pkg::*;
;
	logic clk, nrst, req, volt_req, busy, done, fail, dq_oe, ce_n, oe_n, we_n, hv;
	fcs_op_t op;
	logic [14:0] addr, fa;
	logic [7:0] wdata, rdata, id_dev, dq_out, dev_d, dq_wire;
	int fails = 0;
	int total_checks = 0;
	int cycles = 0;
	assign dq_wire = dq_oe ? dq_out : dev_d;
	fcs_host uut (.clk(clk), .nrst(nrst), .req(req), .op(op), .addr(addr), .wdata(wdata),
		.volt_req(volt_req), .busy(busy), .done(done), .rdata(rdata), .id_dev(id_dev),
		.fail(fail), .flash_addr(fa), .flash_dq_in(dq_wire), .flash_dq_out(dq_out),
		.flash_dq_oe(dq_oe), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
		.program_voltage_input(hv));
	fcs_flash_model dev (.a(fa), .d_in(dq_wire), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
		.hv_on(hv), .d_out(dev_d));
	// ====
	// clock and hang guard
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			fails++;
			$display("MISMATCH %0t timeout", $time);
			results();
		end
	end
	// ====
	// shared tasks
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic do_op(input fcs_op_t o, input logic [14:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		req <= 1'b1;
		op <= o;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		req <= 1'b0;
		// sampled on the falling edge so the done pulse has settled
		while (done !== 1'b1 && n < 800) begin
			@(negedge clk);
			n++;
		end
		check8({7'h00, done}, 8'h01);
	endtask
	// ====
	// scenarios
	task automatic t_read();
		do_op(FCS_OP_READ, 15'h0005, 8'h00);
		check8(rdata, 8'h93);
	endtask
	task automatic t_ident();
		do_op(FCS_OP_IDENT, 15'h0000, 8'h00);
		check8(rdata, 8'h3c);
		check8(id_dev, 8'ha5);
	endtask
	task automatic t_reset();
		do_op(FCS_OP_RESET, 15'h0000, 8'h00);
		do_op(FCS_OP_READ, 15'h0006, 8'h00);
		check8(rdata, 8'h90);
	endtask
	task automatic t_no_volt();
		@(posedge clk);
		volt_req <= 1'b0;
		repeat (4) @(posedge clk);
		do_op(FCS_OP_ERASE, 15'h0010, 8'h00);
		check8({7'h00, fail}, 8'h01);
		check8(rdata, 8'h86);
	endtask
	task automatic t_erase();
		@(posedge clk);
		volt_req <= 1'b1;
		repeat (4) @(posedge clk);
		do_op(FCS_OP_ERASE, 15'h0010, 8'h00);
		check8({7'h00, fail}, 8'h00);
		check8(rdata, 8'hff);
		do_op(FCS_OP_READ, 15'h7abc, 8'h00);
		check8(rdata, 8'hff);
	endtask
	task automatic t_program();
		do_op(FCS_OP_PROGRAM, 15'h0020, 8'h5a);
		do_op(FCS_OP_READ, 15'h0020, 8'h00);
		check8(rdata, 8'h5a);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		req = 1'b0;
		op = FCS_OP_READ;
		addr = 15'h0000;
		wdata = 8'h00;
		volt_req = 1'b0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		volt_req <= 1'b1;
		repeat (4) @(posedge clk);
		t_read();
		t_ident();
		t_reset();
		t_no_volt();
		t_erase();
		t_program();
		results();
	end
endmodule // fcs_host_tb
bind fcs_host fcs_host_monitor mon (.clk(clk), .nrst(nrst), .req(req), .volt_req(volt_req),
	.busy(busy), .done(done), .rdata(rdata), .fail(fail), .flash_addr(flash_addr),
	.flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
	.flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
	.program_voltage_input(program_voltage_input));
